// ===== crt_pkg.sv
// constants, field layouts and opcode kinds of the call, return, vector and bank-swap unit
// assumes a single pclk domain and 32-bit apb data with word-aligned registers
`default_nettype none

package crt_pkg;

  // apb byte offsets
  localparam logic [11:0] ADDR_PC = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_VBASE = 12'h008;
  localparam logic [11:0] ADDR_REGS = 12'h100;
  localparam logic [11:0] ADDR_REGS_END = 12'h17c;

  // status register fields
  localparam int ST_GIE = 0;
  localparam int ST_BANK_A = 1;
  localparam int ST_BANK_B = 2;
  localparam int ST_FLAG_LO = 4;
  localparam int ST_SP_LO = 8;
  localparam int ST_OVF = 16;
  localparam int ST_UNF = 17;

  // register set shape
  localparam int LOG_REGS = 32;
  localparam int PHYS_REGS = 44;
  localparam int BANK_SIZE = 6;
  localparam int NUM_BANKED = 24;
  localparam logic [5:0] BANK_SIZE_6 = 6'h06;
  localparam logic [5:0] GROUP_B_LO = 6'h0c;

  // address stack entry layout
  localparam int E_PC_LO = 0;
  localparam int E_GIE = 16;
  localparam int E_FLAG_LO = 17;
  localparam int E_BANK_A = 21;
  localparam int E_BANK_B = 22;
  localparam int ENTRY_W = 23;
  localparam int STACK_DEPTH = 16;

  // instruction lengths in program words
  localparam logic [15:0] LEN_CALL = 16'h0002;
  localparam logic [15:0] LEN_ONE = 16'h0001;

  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] VBASE_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // interrupt-enable option codes
  localparam logic [1:0] G_KEEP = 2'h0;
  localparam logic [1:0] G_RESTORE = 2'h1;
  localparam logic [1:0] G_SET = 2'h2;
  localparam logic [1:0] G_CLEAR = 2'h3;

  // flag index inside the 4-bit flag field: z, c, v, n
  localparam int FLAG_W = 4;

  typedef enum logic [2:0] {
    OP_SEQ,
    OP_CALL_BIT,
    OP_RET,
    OP_RET_FLAG,
    OP_RET_COND,
    OP_TRAP,
    OP_EXX
  } crt_op_t;

endpackage : crt_pkg

`default_nettype wire

// ===== crt_stack_mem.sv
// address stack storage: one write port, one read port with registered read data
// assumes writer keeps its own pointer and never reads and writes one slot at once
`default_nettype none

module crt_stack_mem #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_data_ff;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
    end else if (rd_en) begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end

  assign rd_data = rd_data_ff;

endmodule : crt_stack_mem

`default_nettype wire

// ===== crt_flow_ctrl.sv
// program-flow unit: bit-tested call, returns, vector call, bank swap and register set
// assumes decoded instruction fields arrive with op_valid and an apb master for setup
// Notes on behaviour
// - the bit-tested call can test any bit of any active register and jumps to a 16-bit absolute target.
// - on a tested-bit match one entry of pc, irq enable, flags and banks is pushed unless the stack is full, and the target loaded, else it falls through.
// - the pc saved by a call or vector call is the address of the next instruction.
// - an unconditional return pops the latest entry and loads its address into the pc.
// - the return irq option keeps, restores from the entry, sets or clears the enable for codes 0 to 3.
// - with restore-flags set a return reloads flags and bank selection from the entry, otherwise both stay.
// - the flag-tested return does a full return with its options only when the chosen flag matches, else goes on.
// - the condition-coded return uses the jump flag selections and codes and returns with its options when met.
// - the vector call takes a vector 0 to 63 and, unless the stack is full, pushes one full entry before jumping.
// - the vector target is the base register as upper byte and an 8-bit form of the vector as lower byte.
// - the vector call clears the irq enable after the push when its flag operand is 1, else leaves it.
// - the register set holds 44 registers, 24 of them in main and alternate banks for groups a and b.
// - the bank swap selects main (0) or alternate (1) independently for group a and group b.
// - registers of a deselected bank keep their contents until selected again.
// - the bank swap irq option keeps for 0, ignores reserved 1, sets for 2 and clears for 3.
`default_nettype none

module crt_flow_ctrl #(
  parameter int STACK_DEPTH = crt_pkg::STACK_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  output logic op_ready,
  input wire crt_pkg::crt_op_t op_kind,
  input wire logic [4:0] op_reg,
  input wire logic [2:0] op_bit,
  input wire logic op_state,
  input wire logic [15:0] op_target,
  input wire logic [1:0] op_gopt,
  input wire logic op_rf,
  input wire logic [1:0] op_flag,
  input wire logic [2:0] op_cond,
  input wire logic [5:0] op_vector,
  input wire logic op_trap_clr,
  input wire logic op_ba,
  input wire logic op_bb,
  output logic [15:0] prog_counter,
  output logic global_irq_enable,
  output logic bank_a_alt,
  output logic bank_b_alt,
  output logic [3:0] alu_flags
);

  localparam int SPW = $clog2(STACK_DEPTH + 1);
  localparam int AW = $clog2(STACK_DEPTH);
  localparam logic [SPW-1:0] SP_FULL = SPW'(STACK_DEPTH);
  typedef enum logic {ST_IDLE, ST_RET_WAIT} crt_state_t;
  crt_state_t state_ff;
  logic [15:0] pc_ff;
  logic gie_ff, bank_a_ff, bank_b_ff, ovf_ff, unf_ff, ret_rf_ff;
  logic [3:0] flags_ff;
  logic [7:0] vbase_ff;
  logic [SPW-1:0] sp_ff;
  logic [1:0] ret_g_ff;
  logic [31:0] prdata_ff;
  logic [7:0] phys_ff [crt_pkg::PHYS_REGS];
  logic accept, bit_hit, flag_hit, cond_hit, call_go, trap_go, ret_go, pop_go;
  logic push, stack_full, stack_empty, apb_setup, apb_wr, is_regs, mapped;
  logic wr_pc, wr_status, wr_vbase, wr_regs;
  logic [15:0] seq_pc, trap_pc;
  logic [crt_pkg::ENTRY_W-1:0] push_entry, pop_entry;
  logic [7:0] cur_reg;
  logic [5:0] wr_phys;
  logic [31:0] nxt_prdata, status_word;

  // logical register to physical slot under the current bank selection
  function automatic logic [5:0] phys_of(input logic [4:0] l, input logic ba, input logic bb);
    logic [5:0] l6;
    l6 = {1'b0, l};
    if (l6 < crt_pkg::BANK_SIZE_6) begin
      phys_of = ba ? l6 + crt_pkg::BANK_SIZE_6 : l6;
    end else if (l6 < crt_pkg::GROUP_B_LO) begin
      phys_of = bb ? l6 + crt_pkg::GROUP_B_LO : l6 + crt_pkg::BANK_SIZE_6;
    end else begin
      phys_of = l6 + crt_pkg::GROUP_B_LO;
    end
  endfunction : phys_of

  // instruction acceptance and condition checks
  assign op_ready = (state_ff == ST_IDLE);
  assign accept = op_valid & op_ready;
  assign cur_reg = phys_ff[phys_of(op_reg, bank_a_ff, bank_b_ff)];
  assign bit_hit = (cur_reg[op_bit] == op_state);
  assign flag_hit = (flags_ff[op_flag] == op_state);
  assign cond_hit = flags_ff[op_cond[2:1]] ^ op_cond[0];
  assign call_go = accept & (op_kind == crt_pkg::OP_CALL_BIT) & bit_hit;
  assign trap_go = accept & (op_kind == crt_pkg::OP_TRAP);
  assign ret_go = accept & ((op_kind == crt_pkg::OP_RET) |
                  ((op_kind == crt_pkg::OP_RET_FLAG) & flag_hit) |
                  ((op_kind == crt_pkg::OP_RET_COND) & cond_hit));
  assign stack_full = (sp_ff == SP_FULL);
  assign stack_empty = (sp_ff == '0);
  assign push = (call_go | trap_go) & !stack_full;
  assign pop_go = ret_go & !stack_empty;
  assign seq_pc = pc_ff + ((op_kind == crt_pkg::OP_CALL_BIT) ? crt_pkg::LEN_CALL
                                                            : crt_pkg::LEN_ONE);
  assign trap_pc = {vbase_ff, 2'h0, op_vector};
  assign push_entry = {bank_b_ff, bank_a_ff, flags_ff, gie_ff, seq_pc};

  crt_stack_mem #(
    .WIDTH(crt_pkg::ENTRY_W),
    .DEPTH(STACK_DEPTH),
    .AW(AW)
  ) u_stack (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(push),
    .wr_addr(sp_ff[AW-1:0]),
    .wr_data(push_entry),
    .rd_en(pop_go),
    .rd_addr(AW'(sp_ff - 1'b1)),
    .rd_data(pop_entry)
  );

  // apb decode, zero wait states
  assign apb_setup = psel & !penable;
  assign apb_wr = psel & penable & pwrite;
  assign is_regs = (paddr >= crt_pkg::ADDR_REGS) && (paddr <= crt_pkg::ADDR_REGS_END) &&
                   (paddr[1:0] == 2'h0);
  assign mapped = (paddr == crt_pkg::ADDR_PC) || (paddr == crt_pkg::ADDR_STATUS) ||
                  (paddr == crt_pkg::ADDR_VBASE) || is_regs;
  assign wr_pc = apb_wr && (paddr == crt_pkg::ADDR_PC);
  assign wr_status = apb_wr && (paddr == crt_pkg::ADDR_STATUS);
  assign wr_vbase = apb_wr && (paddr == crt_pkg::ADDR_VBASE);
  assign wr_regs = apb_wr && is_regs;
  assign wr_phys = phys_of(paddr[6:2], bank_a_ff, bank_b_ff);
  assign pready = 1'b1;
  assign pslverr = psel & penable & !mapped;

  always_comb begin
    status_word = '0;
    status_word[crt_pkg::ST_GIE] = gie_ff;
    status_word[crt_pkg::ST_BANK_A] = bank_a_ff;
    status_word[crt_pkg::ST_BANK_B] = bank_b_ff;
    status_word[crt_pkg::ST_FLAG_LO +: crt_pkg::FLAG_W] = flags_ff;
    status_word[crt_pkg::ST_SP_LO +: SPW] = sp_ff;
    status_word[crt_pkg::ST_OVF] = ovf_ff;
    status_word[crt_pkg::ST_UNF] = unf_ff;
  end

  always_comb begin
    nxt_prdata = '0;
    if (paddr == crt_pkg::ADDR_PC) begin
      nxt_prdata = {16'h0000, pc_ff};
    end else if (paddr == crt_pkg::ADDR_STATUS) begin
      nxt_prdata = status_word;
    end else if (paddr == crt_pkg::ADDR_VBASE) begin
      nxt_prdata = {24'h000000, vbase_ff};
    end else if (is_regs) begin
      nxt_prdata = {24'h000000, phys_ff[phys_of(paddr[6:2], bank_a_ff, bank_b_ff)]};
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (apb_setup && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end
  assign prdata = prdata_ff;

  // sequencer: a taken return waits one cycle for the stack read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      ret_g_ff <= crt_pkg::G_KEEP;
      ret_rf_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (pop_go) begin
            state_ff <= ST_RET_WAIT;
            ret_g_ff <= op_gopt;
            ret_rf_ff <= op_rf;
          end
        end
        ST_RET_WAIT: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff <= crt_pkg::PC_RESET;
    end else if (state_ff == ST_RET_WAIT) begin
      pc_ff <= pop_entry[crt_pkg::E_PC_LO +: 16];
    end else if (call_go) begin
      pc_ff <= op_target;
    end else if (trap_go) begin
      pc_ff <= trap_pc;
    end else if (accept && !pop_go) begin
      pc_ff <= seq_pc;
    end else if (wr_pc) begin
      pc_ff <= pwdata[15:0];
    end
  end

  // global interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_ff <= 1'b0;
    end else if (state_ff == ST_RET_WAIT) begin
      case (ret_g_ff)
        crt_pkg::G_RESTORE: gie_ff <= pop_entry[crt_pkg::E_GIE];
        crt_pkg::G_SET: gie_ff <= 1'b1;
        crt_pkg::G_CLEAR: gie_ff <= 1'b0;
        default: gie_ff <= gie_ff;
      endcase
    end else if (trap_go && op_trap_clr) begin
      gie_ff <= 1'b0;
    end else if (accept && (op_kind == crt_pkg::OP_EXX) && (op_gopt[1] == 1'b1)) begin
      gie_ff <= (op_gopt == crt_pkg::G_SET);
    end else if (wr_status) begin
      gie_ff <= pwdata[crt_pkg::ST_GIE];
    end
  end

  // alu flags and bank selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= crt_pkg::FLAGS_RESET;
      bank_a_ff <= 1'b0;
      bank_b_ff <= 1'b0;
    end else if ((state_ff == ST_RET_WAIT) && ret_rf_ff) begin
      flags_ff <= pop_entry[crt_pkg::E_FLAG_LO +: crt_pkg::FLAG_W];
      bank_a_ff <= pop_entry[crt_pkg::E_BANK_A];
      bank_b_ff <= pop_entry[crt_pkg::E_BANK_B];
    end else if (accept && (op_kind == crt_pkg::OP_EXX)) begin
      bank_a_ff <= op_ba;
      bank_b_ff <= op_bb;
    end else if (wr_status && (state_ff == ST_IDLE) && !accept) begin
      flags_ff <= pwdata[crt_pkg::ST_FLAG_LO +: crt_pkg::FLAG_W];
      bank_a_ff <= pwdata[crt_pkg::ST_BANK_A];
      bank_b_ff <= pwdata[crt_pkg::ST_BANK_B];
    end
  end

  // stack pointer and sticky error flags; a new event beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_ff <= '0;
    end else if (push) begin
      sp_ff <= sp_ff + 1'b1;
    end else if (pop_go) begin
      sp_ff <= sp_ff - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
    end else begin
      if ((call_go || trap_go) && stack_full) begin
        ovf_ff <= 1'b1;
      end else if (wr_status && pwdata[crt_pkg::ST_OVF]) begin
        ovf_ff <= 1'b0;
      end
      if (ret_go && stack_empty) begin
        unf_ff <= 1'b1;
      end else if (wr_status && pwdata[crt_pkg::ST_UNF]) begin
        unf_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbase_ff <= crt_pkg::VBASE_RESET;
    end else if (wr_vbase) begin
      vbase_ff <= pwdata[7:0];
    end
  end

  // physical register set; only the slot mapped by the active banks is written
  for (genvar i = 0; i < crt_pkg::PHYS_REGS; i++) begin : g_phys
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        phys_ff[i] <= 8'h00;
      end else if (wr_regs && (wr_phys == 6'(i))) begin
        phys_ff[i] <= pwdata[7:0];
      end
    end
  end

  assign prog_counter = pc_ff;
  assign global_irq_enable = gie_ff;
  assign bank_a_alt = bank_a_ff;
  assign bank_b_alt = bank_b_ff;
  assign alu_flags = flags_ff;

  // checks
  sequence s_call_taken;
    call_go && !stack_full;
  endsequence
  sequence s_ret_popped;
    pop_go ##1 (state_ff == ST_RET_WAIT);
  endsequence

  a_call_target_load: assert property (@(posedge pclk) disable iff (!presetn)
    s_call_taken |=> (pc_ff == $past(op_target)) && (sp_ff == $past(sp_ff) + 1'b1))
    else $error("call did not load target and push");
  a_call_fall_thru: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && (op_kind == crt_pkg::OP_CALL_BIT) && !bit_hit) |=>
      (pc_ff == $past(pc_ff) + crt_pkg::LEN_CALL) && $stable(sp_ff))
    else $error("untaken call did not fall through");

  a_call_saved_pc: assert property (@(posedge pclk) disable iff (!presetn)
    (push && (op_kind == crt_pkg::OP_CALL_BIT)) |=>
      (u_stack.mem_ff[AW'($past(sp_ff))][crt_pkg::E_PC_LO +: 16] ==
       $past(pc_ff) + crt_pkg::LEN_CALL))
    else $error("saved pc is not the next instruction");
  a_ret_pc_pop: assert property (@(posedge pclk) disable iff (!presetn)
    s_ret_popped |=> (pc_ff == $past(pop_entry[crt_pkg::E_PC_LO +: 16])) && op_ready)
    else $error("return did not load popped address");
  a_ret_gie_opt: assert property (@(posedge pclk) disable iff (!presetn)
    (pop_go && (op_gopt == crt_pkg::G_SET)) |-> ##2 gie_ff)
    else $error("return set option did not set irq enable");

  a_ret_keep_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (pop_go && !op_rf) |-> ##2 (flags_ff == $past(flags_ff, 2)) &&
      (bank_a_ff == $past(bank_a_ff, 2)))
    else $error("return without restore changed flags or banks");
  a_flag_test_return_op_skip: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && (op_kind == crt_pkg::OP_RET_FLAG) && !flag_hit) |=>
      (pc_ff == $past(pc_ff) + crt_pkg::LEN_ONE) && (state_ff == ST_IDLE))
    else $error("untaken flag return did not continue");
  a_trap_target: assert property (@(posedge pclk) disable iff (!presetn)
    trap_go |=> (pc_ff[15:8] == $past(vbase_ff)) && (pc_ff[7:0] == {2'h0, $past(op_vector)}))
    else $error("vector call target wrong");
  a_trap_gie_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (trap_go && op_trap_clr) |=> !gie_ff)
    else $error("vector call did not clear irq enable");

  a_exx_banks: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && (op_kind == crt_pkg::OP_EXX)) |=>
      (bank_a_ff == $past(op_ba)) && (bank_b_ff == $past(op_bb)))
    else $error("bank swap did not select banks");

  a_exx_gie_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && (op_kind == crt_pkg::OP_EXX) && (op_gopt == crt_pkg::G_RESTORE) &&
     !wr_status) |=> $stable(gie_ff))
    else $error("reserved bank swap option changed irq enable");
  a_ret_underflow: assert property (@(posedge pclk) disable iff (!presetn)
    (ret_go && stack_empty) |=> unf_ff && (pc_ff == $past(pc_ff) + crt_pkg::LEN_ONE))
    else $error("return on empty stack was taken");

endmodule : crt_flow_ctrl

`default_nettype wire

// ===== crt_prog_model.sv
// program memory model: presents the instruction word stored at the pc on the op port
// assumes the bench fills mem and raises budget to allow more instructions
`default_nettype none

module crt_prog_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] prog_counter,
  input wire logic op_ready,
  input wire logic [15:0] budget,
  output logic [15:0] taken,
  output logic op_valid,
  output logic [35:0] op_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] mem [256];

  // holds a word until taken, then drops it and scrambles the fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_valid <= 1'b0;
      op_word <= '1;
      taken <= 16'h0000;
    end else if (op_valid && op_ready) begin
      op_valid <= 1'b0;
      op_word <= ~op_word;
      taken <= taken + 16'h0001;
    end else if (!op_valid && op_ready && taken != budget) begin
      op_valid <= 1'b1;
      op_word <= mem[prog_counter[7:0]];
    end
  end
endmodule : crt_prog_model

`default_nettype wire

// ===== call_return_trap_bank_control_tb.sv
// testbench: program memory model feeds the op port, apb task sets up registers
// assumes 250 mhz pclk and the field layout of crt_prog_model words
`default_nettype none

module call_return_trap_bank_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [15:0] budget = 16'h0000;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, op_valid, op_ready, global_irq_enable, bank_a_alt, bank_b_alt;
  wire logic [15:0] prog_counter, taken;
  wire logic [3:0] alu_flags;
  wire logic [35:0] w;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;

  always #2 pclk = ~pclk;

  crt_flow_ctrl u_crt_flow_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_ready(op_ready),
    .op_kind(crt_pkg::crt_op_t'(w[35:33])), .op_reg(w[20:16]), .op_bit(w[23:21]),
    .op_state(w[24]), .op_target(w[15:0]), .op_gopt(w[26:25]), .op_rf(w[27]),
    .op_flag(w[29:28]), .op_cond(w[32:30]), .op_vector(w[5:0]), .op_trap_clr(w[24]),
    .op_ba(w[16]), .op_bb(w[17]), .prog_counter(prog_counter),
    .global_irq_enable(global_irq_enable), .bank_a_alt(bank_a_alt),
    .bank_b_alt(bank_b_alt), .alu_flags(alu_flags));

  crt_prog_model u_crt_prog_model (.pclk(pclk), .presetn(presetn),
    .prog_counter(prog_counter), .op_ready(op_ready), .budget(budget), .taken(taken),
    .op_valid(op_valid), .op_word(w));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic st(input logic g, input logic ba, input logic bb, input logic [3:0] fl);
    apb(1'b1, crt_pkg::ADDR_STATUS, {24'h000000, fl, 1'b0, bb, ba, g});
  endtask : st

  task automatic put(input logic [7:0] a, input crt_pkg::crt_op_t k,
    input logic [15:0] t = 16'h0000, input logic [4:0] r = 5'h00, input logic [2:0] b = 3'h0,
    input logic s = 1'b0, input logic [1:0] g = 2'h0, input logic rf = 1'b0,
    input logic [1:0] f = 2'h0, input logic [2:0] c = 3'h0);
    u_crt_prog_model.mem[a] = {k, c, f, rf, g, s, b, r, t};
  endtask : put

  // runs n instructions from pc p, then lets a return complete
  task automatic run(input logic [15:0] p, input int n);
    apb(1'b1, crt_pkg::ADDR_PC, {16'h0000, p});
    @(posedge pclk);
    budget <= budget + 16'(n);
    do @(posedge pclk); while (taken !== budget);
    repeat (2) @(posedge pclk);
  endtask : run

  task automatic t_reset();
    apb(1'b0, crt_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, crt_pkg::ADDR_VBASE, 32'h0);
    chk("vbase", rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    put(8'h10, crt_pkg::OP_RET);
    run(16'h0010, 1);
    chk("pc", prog_counter, 16'h0011);
    apb(1'b0, crt_pkg::ADDR_STATUS, 32'h0);
    chk("unf", rd, 32'h00020000);
    apb(1'b1, crt_pkg::ADDR_STATUS, 32'h00020000);
    apb(1'b0, crt_pkg::ADDR_STATUS, 32'h0);
    chk("unfclr", rd, 32'h0);
    $display("done reset");
  endtask : t_reset

  task automatic t_call();
    apb(1'b1, crt_pkg::ADDR_REGS + 12'h00c, 32'h5a);
    put(8'h00, crt_pkg::OP_CALL_BIT, 16'h0040, 5'd3, 3'd1, 1'b1);
    put(8'h40, crt_pkg::OP_RET);
    put(8'h02, crt_pkg::OP_CALL_BIT, 16'h0050, 5'd3, 3'd0, 1'b1);
    put(8'h04, crt_pkg::OP_CALL_BIT, 16'h0020, 5'd3, 3'd6, 1'b1);
    put(8'h20, crt_pkg::OP_CALL_BIT, 16'h0030, 5'd3, 3'd4, 1'b1);
    put(8'h30, crt_pkg::OP_RET);
    put(8'h22, crt_pkg::OP_RET);
    run(16'h0000, 1);
    chk("pc", prog_counter, 16'h0040);
    apb(1'b0, crt_pkg::ADDR_STATUS, 32'h0);
    chk("sp", rd[12:8], 32'h1);
    run(16'h0040, 1);
    chk("pc", prog_counter, 16'h0002);
    run(16'h0002, 1);
    chk("pc", prog_counter, 16'h0004);
    run(16'h0004, 2);
    chk("pc", prog_counter, 16'h0030);
    run(16'h0030, 1);
    chk("pc", prog_counter, 16'h0022);
    run(16'h0022, 1);
    chk("pc", prog_counter, 16'h0006);
    $display("done call");
  endtask : t_call

  task automatic t_ret_opts();
    logic [1:0] g;
    for (int i = 0; i < 4; i++) begin
      g = 2'(i);
      put(8'h10, crt_pkg::OP_CALL_BIT, 16'h0060 + 16'(i), 5'd12);
      put(8'h60 + 8'(i), crt_pkg::OP_RET, 16'h0000, 5'h00, 3'h0, 1'b0, g, g[0]);
      st(1'b1, 1'b0, 1'b1, 4'h5);
      run(16'h0010, 1);
      st(1'b0, 1'b1, 1'b0, 4'ha);
      run(16'h0060 + 16'(i), 1);
      chk("gie", global_irq_enable, g == 2'h1 || g == 2'h2);
      chk("flags", alu_flags, g[0] ? 4'h5 : 4'ha);
      chk("banka", bank_a_alt, !g[0]);
      chk("pc", prog_counter, 16'h0012);
    end
    $display("done return options");
  endtask : t_ret_opts

  task automatic t_cond_ret();
    logic [3:0] fl;
    logic x;
    fl = 4'b0101;
    for (int i = 0; i < 16; i++) begin
      x = fl[i[2:1]] ^ i[0];
      put(8'h10, crt_pkg::OP_CALL_BIT, 16'h0080, 5'd12);
      put(8'h80, i[3] ? crt_pkg::OP_RET_COND : crt_pkg::OP_RET_FLAG, 16'h0000, 5'h00,
        3'h0, i[0], 2'h0, 1'b0, i[2:1], 3'(i));
      st(1'b0, 1'b0, 1'b0, fl);
      run(16'h0010, 2);
      if (i[3]) chk("pc", prog_counter, x ? 16'h0012 : 16'h0081);
      else chk("pc", prog_counter, !x ? 16'h0012 : 16'h0081);
    end
    $display("done conditional return");
  endtask : t_cond_ret

  task automatic t_trap();
    logic [5:0] v;
    for (int c = 0; c < 2; c++) begin
      v = c ? 6'h3f : 6'h00;
      apb(1'b1, crt_pkg::ADDR_VBASE, 32'h3c);
      st(1'b1, 1'b0, 1'b0, 4'h0);
      put(8'h10, crt_pkg::OP_TRAP, {10'h000, v}, 5'h00, 3'h0, c[0]);
      put({2'b00, v}, crt_pkg::OP_RET, 16'h0000, 5'h00, 3'h0, 1'b0, 2'h1);
      run(16'h0010, 1);
      chk("pc", prog_counter, {8'h3c, 2'b00, v});
      chk("gie", global_irq_enable, !c[0]);
      run({8'h3c, 2'b00, v}, 1);
      chk("pc", prog_counter, 16'h0011);
      chk("gie", global_irq_enable, 1'b1);
    end
    $display("done trap");
  endtask : t_trap

  task automatic bank_swap_op(input logic ba, input logic bb, input logic [1:0] g, input logic eg);
    put(8'h10, crt_pkg::OP_EXX, 16'h0000, {3'h0, bb, ba}, 3'h0, 1'b0, g);
    run(16'h0010, 1);
    chk("banks", {bank_b_alt, bank_a_alt}, {bb, ba});
    chk("gie", global_irq_enable, eg);
  endtask : bank_swap_op

  task automatic t_exx();
    st(1'b1, 1'b0, 1'b0, 4'h0);
    apb(1'b1, crt_pkg::ADDR_REGS, 32'h11);
    bank_swap_op(1'b1, 1'b1, 2'h3, 1'b0);
    apb(1'b1, crt_pkg::ADDR_REGS, 32'h22);
    bank_swap_op(1'b0, 1'b1, 2'h1, 1'b0);
    apb(1'b0, crt_pkg::ADDR_REGS, 32'h0);
    chk("reg0", rd, 32'h11);
    bank_swap_op(1'b1, 1'b0, 2'h2, 1'b1);
    apb(1'b0, crt_pkg::ADDR_REGS, 32'h0);
    chk("reg0", rd, 32'h22);
    bank_swap_op(1'b0, 1'b0, 2'h0, 1'b1);
    apb(1'b1, crt_pkg::ADDR_REGS + 12'h07c, 32'h77);
    apb(1'b0, crt_pkg::ADDR_REGS + 12'h07c, 32'h0);
    chk("reg31", rd, 32'h77);
    $display("done bank swap");
  endtask : t_exx

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_call();
    t_ret_opts();
    t_cond_ret();
    t_trap();
    t_exx();
    print_verdict();
  end
endmodule : call_return_trap_bank_control_tb

`default_nettype wire
